// ===== hdl/pump_ctrl_pkg.sv
package pump_ctrl_pkg;

  // Register addresses
  localparam logic [7:0] ADDR_REG_CTRL = 8'h00;
  localparam logic [7:0] ADDR_PUMP_CTRL = 8'h23;
  localparam logic [7:0] ADDR_CONN_A = 8'h24;
  localparam logic [7:0] ADDR_CONN_B = 8'h25;

  // Field positions
  localparam int ENABLE_BIT = 2;
  localparam int CLKSEL_BIT = 0;
  localparam int RATIO_LSB = 1;
  localparam int ALG_LSB = 3;
  localparam int LONG_DEB_BIT = 5;
  localparam int AUTO_ON_BIT = 6;
  localparam int CONN_A_BITS = 7;
  localparam int CONN_B_LOW_BITS = 5;
  localparam int CONN_B_HV3_BIT = 7;
  localparam int NUM_SINKS = 13;
  localparam int NUM_LV_SINKS = 10;
  localparam int NUM_HV_SINKS = 3;

  // Reset values
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [1:0] RESET_FIELD2 = 2'h0;

  // Ratio encodings
  localparam logic [1:0] RATIO_1X = 2'h0;
  localparam logic [1:0] RATIO_1X5 = 2'h1;
  localparam logic [1:0] RATIO_2X = 2'h2;
  localparam logic [1:0] RATIO_NA = 2'h3;

  // Switching algorithm encodings
  localparam logic [1:0] ALG_AUTO_ALL = 2'h0;
  localparam logic [1:0] ALG_AUTO_LIM = 2'h1;
  localparam logic [1:0] ALG_MANUAL = 2'h2;
  localparam logic [1:0] ALG_RSVD = 2'h3;

  // Timing
  localparam longint CLK_PERIOD_PS = 4000;
  localparam longint CLK_FREQ_KHZ = 250000;
  localparam longint DEB_SHORT_US = 240;
  localparam longint DEB_LONG_MS = 2;
  localparam int DEB_SHORT_CYC = int'((DEB_SHORT_US * 1000000) / CLK_PERIOD_PS);
  localparam int DEB_LONG_CYC = int'((DEB_LONG_MS * 1000000000) / CLK_PERIOD_PS);
  localparam int DEB_W = 20;
  localparam longint PUMP_FAST_KHZ = 1000;
  localparam longint PUMP_SLOW_KHZ = 500;
  localparam int HALF_FAST_CYC = int'(CLK_FREQ_KHZ / (2 * PUMP_FAST_KHZ));
  localparam int HALF_SLOW_CYC = int'(CLK_FREQ_KHZ / (2 * PUMP_SLOW_KHZ));
  localparam int DIV_W = 9;
  localparam longint SOFT_STEP_NS = 1000;
  localparam int SOFT_STEP_CYC = int'((SOFT_STEP_NS * 1000) / CLK_PERIOD_PS);
  localparam int SOFT_LEVEL_W = 4;

endpackage : pump_ctrl_pkg

// ===== hdl/pump_soft_start.sv
`timescale 1ns/10ps
module pump_soft_start #(
  parameter int STEP_CYCLES = pump_ctrl_pkg::SOFT_STEP_CYC,
  parameter int LEVEL_W = pump_ctrl_pkg::SOFT_LEVEL_W
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Control
  input wire logic start_i,
  input wire logic enable_i,
  // Ramp state
  output logic [LEVEL_W-1:0] level_o,
  output logic busy_o
);
  import pump_ctrl_pkg::*;

  localparam logic [LEVEL_W-1:0] LEVEL_MAX = '1;
  localparam logic [15:0] STEP_LAST = 16'(STEP_CYCLES - 1);

  logic [15:0] step_cnt_reg;

  // Ramp restarts from zero on every trigger, then climbs one level per step
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      level_o <= '0;
      busy_o <= 1'b0;
      step_cnt_reg <= 16'h0000;
    end else if (!enable_i) begin
      level_o <= '0;
      busy_o <= 1'b0;
      step_cnt_reg <= 16'h0000;
    end else if (start_i) begin
      level_o <= '0;
      busy_o <= 1'b1;
      step_cnt_reg <= 16'h0000;
    end else if (busy_o) begin
      if (step_cnt_reg == STEP_LAST) begin
        step_cnt_reg <= 16'h0000;
        level_o <= level_o + 1'b1;
        busy_o <= (level_o != LEVEL_MAX - 1'b1);
      end else begin
        step_cnt_reg <= step_cnt_reg + 16'h0001;
      end
    end
  end

endmodule : pump_soft_start

// ===== hdl/charge_pump_mode_control.sv
`timescale 1ns/10ps
// What this block does
// - In either automatic setting, watch only sinks whose connection flag is set.
// - Any watched sink low steps the ratio up once debounce has elapsed.
// - Restricted automatic setting never enters the 1:2 ratio.
// - Unflagged sink low indications never cause an up-step.
// - Enable bit 2 of 00h; clear holds 1:1 unless auto turn-on.
// - Bit 0 of 23h selects 1 MHz (0) or 500 kHz (1).
// - Ratio field 2:1; manual writes set it, automatic reads show live ratio.
// - Algorithm field 4:3: auto all, auto limited, manual, reserved.
// - Bit 5 makes first debounce after enable 2ms, else 240us.
// - Bit 6 turns pump on when any connected sink is on.
// - Soft start ramps at turn-on and at every ratio change while the pump is on.
// - 24h bits 0-6 flag four parallel then three colour sinks.
// - 25h bits 0-3 flag hv sinks 1,2 and general 1,2; reset 0.
// - 25h bit 4 flags general sink 3, bit 7 hv sink 3.
// - Hv sinks use hv comparator, all others the lv comparator.
module charge_pump_mode_control #(
  parameter int DEB_SHORT_CYCLES = pump_ctrl_pkg::DEB_SHORT_CYC,
  parameter int DEB_LONG_CYCLES = pump_ctrl_pkg::DEB_LONG_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Register port
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // Sink status
  input wire logic [pump_ctrl_pkg::NUM_LV_SINKS-1:0] lv_low_i,
  input wire logic [pump_ctrl_pkg::NUM_HV_SINKS-1:0] hv_low_i,
  input wire logic [pump_ctrl_pkg::NUM_SINKS-1:0] sink_on_i,
  // Pump control
  output logic pump_active_o,
  output logic [1:0] pump_ratio_o,
  output logic pump_clk_o,
  output logic [pump_ctrl_pkg::SOFT_LEVEL_W-1:0] pump_soft_level_o,
  output logic pump_soft_busy_o
);
  import pump_ctrl_pkg::*;

  typedef enum logic [1:0] {ST_OFF, ST_FIRST_DEB, ST_RUN} pump_state_e;

  localparam logic [DEB_W-1:0] DEB_SHORT_LAST = DEB_W'(DEB_SHORT_CYCLES - 1);
  localparam logic [DEB_W-1:0] DEB_LONG_LAST = DEB_W'(DEB_LONG_CYCLES - 1);
  localparam logic [DIV_W-1:0] HALF_FAST_LAST = DIV_W'(HALF_FAST_CYC - 1);
  localparam logic [DIV_W-1:0] HALF_SLOW_LAST = DIV_W'(HALF_SLOW_CYC - 1);

  function automatic logic [1:0] top_ratio(input logic [1:0] alg);
    top_ratio = (alg == ALG_AUTO_LIM) ? RATIO_1X5 : RATIO_2X;
  endfunction : top_ratio

  function automatic logic is_auto(input logic [1:0] alg);
    is_auto = (alg == ALG_AUTO_ALL) || (alg == ALG_AUTO_LIM);
  endfunction : is_auto

  logic enable_reg;
  logic clksel_reg;
  logic [1:0] ratio_field_reg;
  logic [1:0] alg_reg;
  logic long_deb_reg;
  logic auto_on_reg;
  logic [CONN_A_BITS-1:0] conn_a_reg;
  logic [CONN_B_LOW_BITS-1:0] conn_b_reg;
  logic conn_hv3_reg;
  logic [NUM_SINKS-1:0] low_meta_reg;
  logic [NUM_SINKS-1:0] low_sync_reg;
  logic [NUM_SINKS-1:0] conn_vec;
  logic [NUM_SINKS-1:0] low_vec;
  logic pump_on_next;
  pump_state_e state_reg;
  logic [DEB_W-1:0] deb_cnt_reg;
  logic [DEB_W-1:0] deb_last;
  logic watch;
  logic step_up;
  logic [1:0] manual_target;
  logic [1:0] ratio_next;
  logic [DIV_W-1:0] div_cnt_reg;
  logic [DIV_W-1:0] div_last;
  logic soft_trigger;
  logic wr_ctrl;
  logic wr_pump;

  // Sink order: par0-3, colour1-3, hv1, hv2, gen1-3, hv3
  assign conn_vec = {conn_hv3_reg, conn_b_reg, conn_a_reg};
  assign low_vec = {hv_low_i[2], lv_low_i[9:7], hv_low_i[1:0], lv_low_i[6:0]};

  assign wr_ctrl = reg_wr_i && (reg_addr_i == ADDR_REG_CTRL);
  assign wr_pump = reg_wr_i && (reg_addr_i == ADDR_PUMP_CTRL);

  // Register writes
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      enable_reg <= 1'b0;
    end else if (wr_ctrl) begin
      enable_reg <= reg_wdata_i[ENABLE_BIT];
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      clksel_reg <= 1'b0;
      ratio_field_reg <= RESET_FIELD2;
      alg_reg <= RESET_FIELD2;
      long_deb_reg <= 1'b0;
      auto_on_reg <= 1'b0;
    end else if (wr_pump) begin
      clksel_reg <= reg_wdata_i[CLKSEL_BIT];
      ratio_field_reg <= reg_wdata_i[RATIO_LSB +: 2];
      alg_reg <= reg_wdata_i[ALG_LSB +: 2];
      long_deb_reg <= reg_wdata_i[LONG_DEB_BIT];
      auto_on_reg <= reg_wdata_i[AUTO_ON_BIT];
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      conn_a_reg <= RESET_BYTE[CONN_A_BITS-1:0];
      conn_b_reg <= RESET_BYTE[CONN_B_LOW_BITS-1:0];
      conn_hv3_reg <= 1'b0;
    end else if (reg_wr_i && reg_addr_i == ADDR_CONN_A) begin
      conn_a_reg <= reg_wdata_i[CONN_A_BITS-1:0];
    end else if (reg_wr_i && reg_addr_i == ADDR_CONN_B) begin
      conn_b_reg <= reg_wdata_i[CONN_B_LOW_BITS-1:0];
      conn_hv3_reg <= reg_wdata_i[CONN_B_HV3_BIT];
    end
  end

  // Register reads, one cycle latency
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      reg_rdata_o <= RESET_BYTE;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        ADDR_REG_CTRL: reg_rdata_o <= 8'(enable_reg) << ENABLE_BIT;
        ADDR_PUMP_CTRL: reg_rdata_o <= {1'b0, auto_on_reg, long_deb_reg, alg_reg,
          (is_auto(alg_reg) ? pump_ratio_o : ratio_field_reg), clksel_reg};
        ADDR_CONN_A: reg_rdata_o <= {1'b0, conn_a_reg};
        ADDR_CONN_B: reg_rdata_o <= {conn_hv3_reg, 2'b00, conn_b_reg};
        default: reg_rdata_o <= RESET_BYTE;
      endcase
    end
  end

  // Comparator levels are asynchronous to this clock
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      low_meta_reg <= '0;
      low_sync_reg <= '0;
    end else begin
      low_meta_reg <= low_vec;
      low_sync_reg <= low_meta_reg;
    end
  end

  // Pump on/off
  assign pump_on_next = enable_reg || (auto_on_reg && |(sink_on_i & conn_vec));

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      pump_active_o <= 1'b0;
    end else begin
      pump_active_o <= pump_on_next;
    end
  end

  // Startup state: long first debounce tracked until the first up-step
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_reg <= ST_OFF;
    end else if (!pump_active_o) begin
      state_reg <= ST_OFF;
    end else begin
      case (state_reg)
        ST_OFF: state_reg <= long_deb_reg ? ST_FIRST_DEB : ST_RUN;
        ST_FIRST_DEB: state_reg <= step_up ? ST_RUN : ST_FIRST_DEB;
        ST_RUN: state_reg <= ST_RUN;
        default: state_reg <= ST_OFF;
      endcase
    end
  end

  // Debounce of watched low indications
  assign deb_last = (state_reg == ST_FIRST_DEB) ? DEB_LONG_LAST : DEB_SHORT_LAST;
  assign watch = pump_active_o && (state_reg != ST_OFF) && is_auto(alg_reg)
    && (pump_ratio_o < top_ratio(alg_reg))
    && |(low_sync_reg & conn_vec);
  assign step_up = watch && (deb_cnt_reg == deb_last);

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      deb_cnt_reg <= '0;
    end else if (!watch || step_up) begin
      deb_cnt_reg <= '0;
    end else begin
      deb_cnt_reg <= deb_cnt_reg + 1'b1;
    end
  end

  // Ratio selection
  assign manual_target = (ratio_field_reg == RATIO_NA) ? RATIO_1X : ratio_field_reg;

  always_comb begin
    ratio_next = pump_ratio_o;
    if (!pump_active_o) begin
      ratio_next = RATIO_1X;
    end else if (alg_reg == ALG_MANUAL) begin
      ratio_next = manual_target;
    end else if (step_up) begin
      ratio_next = pump_ratio_o + 2'h1;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      pump_ratio_o <= RATIO_1X;
    end else begin
      pump_ratio_o <= ratio_next;
    end
  end

  // Pump clock divider
  assign div_last = clksel_reg ? HALF_SLOW_LAST : HALF_FAST_LAST;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      div_cnt_reg <= '0;
      pump_clk_o <= 1'b0;
    end else if (!pump_active_o) begin
      div_cnt_reg <= '0;
      pump_clk_o <= 1'b0;
    end else if (div_cnt_reg >= div_last) begin
      div_cnt_reg <= '0;
      pump_clk_o <= !pump_clk_o;
    end else begin
      div_cnt_reg <= div_cnt_reg + 1'b1;
    end
  end

  // Soft start on turn-on and ratio change
  assign soft_trigger = (pump_on_next && !pump_active_o)
    || (pump_active_o && ratio_next != pump_ratio_o);

  pump_soft_start #(
    .STEP_CYCLES(SOFT_STEP_CYC),
    .LEVEL_W(SOFT_LEVEL_W)
  ) u_soft_start (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .start_i(soft_trigger),
    .enable_i(pump_on_next),
    .level_o(pump_soft_level_o),
    .busy_o(pump_soft_busy_o)
  );

  // Checks
  sequence s_turn_on;
    !pump_active_o ##1 pump_active_o;
  endsequence

  sequence s_ratio_moves;
    pump_active_o && $changed(pump_ratio_o);
  endsequence

  AST_NO_UNWATCHED_STEP: assert property (@(posedge clk_i) disable iff (reset_i)
    (pump_active_o && is_auto(alg_reg) && !(|(low_sync_reg & conn_vec)))
    |=> $stable(pump_ratio_o))
    else $error("ratio moved without a watched low sink");

  AST_LIMITED_NO_DOUBLE: assert property (@(posedge clk_i) disable iff (reset_i)
    (alg_reg == ALG_AUTO_LIM && pump_ratio_o != RATIO_2X) |=> pump_ratio_o != RATIO_2X)
    else $error("limited automatic setting entered 1:2");

  AST_OFF_IS_1X: assert property (@(posedge clk_i) disable iff (reset_i)
    !pump_active_o |=> pump_ratio_o == RATIO_1X && !pump_clk_o)
    else $error("pump off but not in 1:1");

  // A select change may leave the count past the new limit; skip that one toggle
  AST_CLK_HALF_PERIOD: assert property (@(posedge clk_i) disable iff (reset_i)
    (pump_active_o && $past(pump_active_o) && $stable(clksel_reg)
      && $past(clksel_reg, 2) == clksel_reg && $changed(pump_clk_o))
    |-> $past(div_cnt_reg) == div_last)
    else $error("pump clock toggled at wrong count");

  AST_MANUAL_FOLLOWS: assert property (@(posedge clk_i) disable iff (reset_i)
    (pump_active_o && alg_reg == ALG_MANUAL) |=> pump_ratio_o == $past(manual_target))
    else $error("manual ratio not applied");

  AST_AUTO_UP_ONLY: assert property (@(posedge clk_i) disable iff (reset_i)
    (pump_active_o && is_auto(alg_reg))
    |=> (pump_ratio_o == $past(pump_ratio_o) || pump_ratio_o == $past(pump_ratio_o) + 2'h1))
    else $error("automatic ratio moved other than one step up");

  AST_STEP_AFTER_DEBOUNCE: assert property (@(posedge clk_i) disable iff (reset_i)
    (pump_active_o && is_auto($past(alg_reg)) && pump_ratio_o != $past(pump_ratio_o)
      && $past(pump_active_o))
    |-> $past(deb_cnt_reg) == $past(deb_last) && $past(watch))
    else $error("up-step without full debounce");

  AST_LONG_FIRST: assert property (@(posedge clk_i) disable iff (reset_i)
    (s_turn_on ##1 1'b1) |-> state_reg == ($past(long_deb_reg) ? ST_FIRST_DEB : ST_RUN))
    else $error("first debounce length not chosen at turn-on");

  AST_AUTO_TURN_ON: assert property (@(posedge clk_i) disable iff (reset_i)
    (auto_on_reg && |(sink_on_i & conn_vec)) |=> pump_active_o)
    else $error("auto turn-on did not start pump");

  AST_SOFT_ON_CHANGE: assert property (@(posedge clk_i) disable iff (reset_i)
    (s_ratio_moves or s_turn_on) |-> pump_soft_busy_o && pump_soft_level_o == '0)
    else $error("soft start not started");

endmodule : charge_pump_mode_control

// ===== test/pump_sink_model.sv
`timescale 1ns/10ps
module pump_sink_model (
  // Pump state seen by the sinks
  input wire logic pump_active_i,
  input wire logic [1:0] pump_ratio_i,
  // Scenario control
  input wire logic [pump_ctrl_pkg::NUM_SINKS-1:0] weak_i,
  input wire logic [1:0] need_i,
  // Comparator flags
  output logic [pump_ctrl_pkg::NUM_LV_SINKS-1:0] lv_low_o,
  output logic [pump_ctrl_pkg::NUM_HV_SINKS-1:0] hv_low_o
);
  import pump_ctrl_pkg::*;
  logic [NUM_SINKS-1:0] low;
  // Weak sinks sag until the pump reaches the ratio they need
  assign low = weak_i & {NUM_SINKS{!pump_active_i || (pump_ratio_i < need_i)}};
  // Hv sinks feed the hv comparator, all others the lv one
  assign lv_low_o = {low[11:9], low[6:0]};
  assign hv_low_o = {low[12], low[8:7]};
endmodule : pump_sink_model

// ===== test/charge_pump_mode_control_test.sv
`timescale 1ns/10ps
module charge_pump_mode_control_test;
  import pump_ctrl_pkg::*;
  localparam int DS = 20;
  localparam int DL = 50;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [7:0] reg_addr_i = 8'h00;
  logic reg_wr_i = 1'b0;
  logic [7:0] reg_wdata_i = 8'h00;
  logic reg_rd_i = 1'b0;
  logic [7:0] reg_rdata_o;
  logic [NUM_LV_SINKS-1:0] lv_low_i;
  logic [NUM_HV_SINKS-1:0] hv_low_i;
  logic [NUM_SINKS-1:0] sink_on_i = '0;
  logic [NUM_SINKS-1:0] weak_sinks = '0;
  logic [1:0] need_ratio = 2'h0;
  logic pump_active_o;
  logic [1:0] pump_ratio_o;
  logic pump_clk_o;
  logic [SOFT_LEVEL_W-1:0] pump_soft_level_o;
  logic pump_soft_busy_o;
  int bad_count = 0;
  int n_compared = 0;
  int n;

  charge_pump_mode_control #(.DEB_SHORT_CYCLES(DS), .DEB_LONG_CYCLES(DL)) u_dut (
    .clk_i(clk_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
    .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .lv_low_i(lv_low_i), .hv_low_i(hv_low_i), .sink_on_i(sink_on_i),
    .pump_active_o(pump_active_o), .pump_ratio_o(pump_ratio_o), .pump_clk_o(pump_clk_o),
    .pump_soft_level_o(pump_soft_level_o), .pump_soft_busy_o(pump_soft_busy_o));

  pump_sink_model u_model (
    .pump_active_i(pump_active_o), .pump_ratio_i(pump_ratio_o), .weak_i(weak_sinks),
    .need_i(need_ratio), .lv_low_o(lv_low_i), .hv_low_o(hv_low_i));

  always #2 clk_i = ~clk_i;

  task close_out;
    if (bad_count == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : close_out

  task check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task cycles(input int k);
    repeat (k) @(negedge clk_i);
  endtask : cycles

  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    @(negedge clk_i);
    reg_wr_i = 1'b0;
  endtask : wr

  task rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk_i);
    reg_addr_i = a;
    reg_rd_i = 1'b1;
    @(negedge clk_i);
    reg_rd_i = 1'b0;
    check(reg_rdata_o, exp);
  endtask : rd

  task wait_ratio(input logic [1:0] r, output int k);
    k = 0;
    while (pump_ratio_o !== r && k < 2000) begin
      @(negedge clk_i);
      k++;
    end
  endtask : wait_ratio

  // Half period of the pump clock in system cycles
  task half(output int k);
    @(posedge pump_clk_o);
    @(negedge clk_i);
    k = 0;
    while (pump_clk_o === 1'b1 && k < 1000) begin
      @(negedge clk_i);
      k++;
    end
  endtask : half

  task t_regs;
    rd(ADDR_REG_CTRL, 8'h00);
    rd(ADDR_PUMP_CTRL, 8'h00);
    rd(ADDR_CONN_A, 8'h00);
    rd(ADDR_CONN_B, 8'h00);
    wr(ADDR_CONN_A, 8'hFF);
    rd(ADDR_CONN_A, 8'h7F);
    wr(ADDR_CONN_B, 8'hFF);
    rd(ADDR_CONN_B, 8'h9F);
    wr(ADDR_PUMP_CTRL, 8'hFF);
    rd(ADDR_PUMP_CTRL, 8'h7F);
    wr(8'h30, 8'hAA);
    rd(8'h30, 8'h00);
    wr(ADDR_PUMP_CTRL, 8'h00);
    wr(ADDR_CONN_A, 8'h00);
    wr(ADDR_CONN_B, 8'h00);
    wr(ADDR_REG_CTRL, 8'hFF);
    rd(ADDR_REG_CTRL, 8'h04);
    wr(ADDR_REG_CTRL, 8'h00);
    cycles(2);
    check({7'h00, pump_active_o}, 8'h00);
  endtask : t_regs

  task t_manual;
    wr(ADDR_PUMP_CTRL, 8'h12);
    cycles(2);
    check({6'h00, pump_ratio_o}, 8'h00);
    wr(ADDR_REG_CTRL, 8'h04);
    cycles(2);
    check({6'h00, pump_active_o, pump_soft_busy_o}, 8'h03);
    check({6'h00, pump_ratio_o}, {6'h00, RATIO_1X5});
    half(n);
    check({7'h00, n == HALF_FAST_CYC}, 8'h01);
    wr(ADDR_PUMP_CTRL, 8'h13);
    half(n);
    half(n);
    check({7'h00, n == HALF_SLOW_CYC}, 8'h01);
    // Through 1:1 on the way to 1:2
    wr(ADDR_PUMP_CTRL, 8'h10);
    cycles(1);
    check({pump_soft_busy_o, 1'b0, pump_ratio_o, pump_soft_level_o}, 8'h80);
    // Ramp climbs one level per step
    cycles(SOFT_STEP_CYC);
    check({pump_soft_busy_o, 3'h0, pump_soft_level_o}, 8'h81);
    wr(ADDR_PUMP_CTRL, 8'h14);
    cycles(1);
    check({6'h00, pump_ratio_o}, {6'h00, RATIO_2X});
    wr(ADDR_PUMP_CTRL, 8'h16);
    cycles(1);
    check({6'h00, pump_ratio_o}, 8'h00);
    wr(ADDR_REG_CTRL, 8'h00);
    cycles(2);
    check({5'h00, pump_active_o, pump_ratio_o}, 8'h00);
  endtask : t_manual

  task t_auto(input logic long_deb);
    int first;
    first = long_deb ? DL : DS;
    wr(ADDR_CONN_A, 8'h01);
    wr(ADDR_CONN_B, 8'h80);
    wr(ADDR_PUMP_CTRL, {2'b00, long_deb, 5'h00});
    weak_sinks = 13'h1000;
    need_ratio = RATIO_2X;
    wr(ADDR_REG_CTRL, 8'h04);
    wait_ratio(RATIO_1X5, n);
    check({7'h00, n >= first && n <= first + 6}, 8'h01);
    wait_ratio(RATIO_2X, n);
    check({7'h00, n >= DS - 1 && n <= DS + 4}, 8'h01);
    rd(ADDR_PUMP_CTRL, {2'b00, long_deb, 5'h04});
    cycles(3 * DS);
    check({6'h00, pump_ratio_o}, {6'h00, RATIO_2X});
    wr(ADDR_REG_CTRL, 8'h00);
    cycles(2);
    check({5'h00, pump_active_o, pump_ratio_o}, 8'h00);
    wr(ADDR_REG_CTRL, 8'h04);
    cycles(2);
    check({5'h00, pump_active_o, pump_ratio_o}, 8'h04);
    wr(ADDR_REG_CTRL, 8'h00);
    weak_sinks = '0;
  endtask : t_auto

  task t_limited;
    wr(ADDR_CONN_A, 8'h01);
    wr(ADDR_CONN_B, 8'h00);
    wr(ADDR_PUMP_CTRL, 8'h08);
    weak_sinks = 13'h0002;
    need_ratio = RATIO_2X;
    wr(ADDR_REG_CTRL, 8'h04);
    cycles(3 * DS);
    check({6'h00, pump_ratio_o}, 8'h00);
    weak_sinks = 13'h0003;
    wait_ratio(RATIO_1X5, n);
    check({7'h00, n >= DS && n <= DS + 6}, 8'h01);
    cycles(4 * DS);
    check({6'h00, pump_ratio_o}, {6'h00, RATIO_1X5});
    wr(ADDR_REG_CTRL, 8'h00);
    weak_sinks = '0;
  endtask : t_limited

  task t_auto_on;
    wr(ADDR_CONN_A, 8'h01);
    wr(ADDR_PUMP_CTRL, 8'h40);
    sink_on_i = 13'h0002;
    cycles(4);
    check({7'h00, pump_active_o}, 8'h00);
    sink_on_i = 13'h0001;
    cycles(2);
    check({7'h00, pump_active_o}, 8'h01);
    sink_on_i = '0;
    cycles(2);
    check({7'h00, pump_active_o}, 8'h00);
  endtask : t_auto_on

  initial begin
    #200000;
    bad_count++;
    close_out();
  end

  initial begin
    repeat (10) @(negedge clk_i);
    reset_i = 1'b0;
    check({5'h00, pump_active_o, pump_ratio_o}, 8'h00);
    t_regs();
    t_manual();
    t_auto(1'b0);
    t_auto(1'b1);
    t_limited();
    t_auto_on();
    close_out();
  end
endmodule : charge_pump_mode_control_test
